// *** prot_pkg.sv ***
`default_nettype none
package prot_pkg;
   // ****************************************
   // Modes, operations, descriptor kinds
   // ****************************************
   typedef enum logic [2:0] {
      MODE_REAL = 3'b001,
      MODE_PROT = 3'b010,
      MODE_V86 = 3'b100
   } mode_t;
   typedef enum logic [2:0] {OP_JMP, OP_CALL, OP_RET, OP_IRET, OP_INT, OP_EXC, OP_EXT} op_t;
   typedef enum logic [2:0] {DT_CODE, DT_CALL_GATE, DT_TRAP_GATE, DT_INT_GATE, DT_TASK_GATE, DT_TSS} dtype_t;
   typedef enum logic [1:0] {TB_GLOBAL, TB_LOCAL, TB_INTR} tbl_t;
   typedef enum logic [3:0] {
      IN_PLAIN, IN_PRIV, IN_CLI, IN_STI, IN_INTN, IN_IRET,
      IN_PUSHF, IN_POPF, IN_INT3, IN_INTO, IN_BOUND, IN_IO
   } insn_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      op_t op;
      dtype_t dtype;
      tbl_t tbl;
      logic nested_task_flag;
      logic [1:0] requested_priv_level;
      logic [1:0] descriptor_priv_level;
      logic [1:0] tgt_dpl;
      logic conforming;
      logic is32;
      logic img_vm;
      logic [15:0] outer_ss;
      logic [31:0] outer_sp;
   } xfer_req_t;
   typedef struct packed {
      logic fault;
      logic task_sw;
      logic stk_sw;
      logic push_old;
      logic vm_saved;
      logic [1:0] current_priv_level;
      logic [15:0] new_ss;
      logic [31:0] new_sp;
      logic [15:0] old_ss;
      logic [31:0] old_sp;
   } xfer_rsp_t;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [7:0] REG_CTRL0 = 8'h00;
   localparam logic [7:0] REG_FLAGS = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_STK_SEL = 8'h0c;
   localparam logic [7:0] REG_STK_PTR = 8'h10;
   localparam logic [7:0] REG_LIMIT = 8'h14;
   localparam logic [2:0] TSS_BANK = 3'h1;
   localparam int PE_BIT = 0;
   localparam int PG_BIT = 31;
   localparam int IO_PRIV_LEVEL_LO = 12;
   localparam int NT_BIT = 14;
   localparam int VM_BIT = 17;
   localparam int ST_MODE_LO = 2;
   localparam int ST_FAULT_BIT = 8;
   localparam int SEG_SHIFT = 4;
   localparam logic [1:0] CPL_RST = 2'h0;
   localparam logic [1:0] IO_PRIV_LEVEL_RST = 2'h0;
   localparam logic [1:0] V86_CPL = 2'h3;
   localparam logic [31:0] LIMIT_RST = 32'h0000ffff;
   localparam logic [31:0] V86_LIMIT = 32'h0000ffff;
   localparam logic [31:0] V86_TOP = 32'h000fffff;
   localparam logic [31:0] STK_RST = 32'h00000000;
endpackage
`default_nettype wire

// *** priv_xfer_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module priv_xfer_ctrl (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Control transfer
   input wire logic xfer_valid_in,
   input wire prot_pkg::xfer_req_t xfer_req_in,
   output logic xfer_done_out,
   output prot_pkg::xfer_rsp_t xfer_rsp_out,
   // Instruction check
   input wire logic insn_valid_in,
   input wire prot_pkg::insn_t insn_in,
   output logic insn_done_out,
   output logic insn_fault_out,
   // Address formation
   input wire logic addr_valid_in,
   input wire logic [15:0] seg_in,
   input wire logic [31:0] off_in,
   output logic addr_done_out,
   output logic [31:0] lin_addr_out,
   output logic overrun_out,
   output logic page_xlate_out,
   // State
   output logic [1:0] current_priv_level_out,
   output logic emulation_mode_flag_out
);
   // ****************************************
   // State
   // ****************************************
   prot_pkg::mode_t mode_r;
   logic [1:0] cpl_r, io_priv_level_r;
   logic pe_r, pg_r, nt_r, fault_r;
   logic [31:0] limit_r;
   logic [15:0] ss_r;
   logic [31:0] sp_r;
   logic [15:0] tss_ss_r [0:2];
   logic [31:0] tss_sp_r [0:2];
   prot_pkg::xfer_req_t r;
   assign r = xfer_req_in;
   // ****************************************
   // Transfer check
   // ****************************************
   logic [1:0] effective_priv_level, ncpl;
   logic ok, ts, to_v86, from_v86, seg_tbl, is_intr, gate_ok, sw, inward, commit, xfault;
   always_comb begin
      effective_priv_level = (r.requested_priv_level > cpl_r) ? r.requested_priv_level : cpl_r;
      seg_tbl = (r.tbl != prot_pkg::TB_INTR);
      is_intr = r.op inside {prot_pkg::OP_INT, prot_pkg::OP_EXC, prot_pkg::OP_EXT};
      gate_ok = (r.op != prot_pkg::OP_INT) || (effective_priv_level <= r.descriptor_priv_level);
      ok = 1'b0;
      ts = 1'b0;
      ncpl = cpl_r;
      to_v86 = 1'b0;
      if (mode_r == prot_pkg::MODE_REAL) begin
         ok = 1'b1;
      end else if (mode_r == prot_pkg::MODE_V86 && !is_intr) begin
         // Emulated code transfers stay inside the task
         ok = 1'b1;
      end else begin
         unique case (r.op)
            prot_pkg::OP_JMP, prot_pkg::OP_CALL: begin
               if (r.dtype == prot_pkg::DT_CODE && seg_tbl) begin
                  ok = (effective_priv_level <= r.descriptor_priv_level) && (r.conforming ?
                     r.descriptor_priv_level <= cpl_r : r.descriptor_priv_level == cpl_r);
               end else if (r.dtype == prot_pkg::DT_CALL_GATE && seg_tbl) begin
                  ok = (effective_priv_level <= r.descriptor_priv_level) && (r.tgt_dpl <= cpl_r)
                     && (r.op == prot_pkg::OP_CALL || r.conforming || r.tgt_dpl == cpl_r);
                  ncpl = r.conforming ? cpl_r : r.tgt_dpl;
               end else if ((r.dtype == prot_pkg::DT_TSS && r.tbl == prot_pkg::TB_GLOBAL)
                  || (r.dtype == prot_pkg::DT_TASK_GATE && seg_tbl)) begin
                  ok = (effective_priv_level <= r.descriptor_priv_level);
                  ts = 1'b1;
               end
            end
            prot_pkg::OP_RET, prot_pkg::OP_IRET: begin
               if (r.op == prot_pkg::OP_IRET && r.nested_task_flag) begin
                  ok = (r.dtype == prot_pkg::DT_TASK_GATE) && !seg_tbl;
                  ts = 1'b1;
               end else if (r.op == prot_pkg::OP_IRET && cpl_r == 2'h0 && r.img_vm) begin
                  ok = 1'b1;
                  to_v86 = 1'b1;
                  ncpl = prot_pkg::V86_CPL;
               end else begin
                  ok = (r.dtype == prot_pkg::DT_CODE) && seg_tbl && (r.requested_priv_level >= cpl_r)
                     && (r.conforming ? r.descriptor_priv_level <= r.requested_priv_level
                     : r.descriptor_priv_level == r.requested_priv_level);
                  ncpl = r.requested_priv_level;
               end
            end
            prot_pkg::OP_INT, prot_pkg::OP_EXC, prot_pkg::OP_EXT: begin
               if (!seg_tbl && r.dtype inside {prot_pkg::DT_TRAP_GATE, prot_pkg::DT_INT_GATE}) begin
                  ok = gate_ok && (r.tgt_dpl <= cpl_r) && (mode_r != prot_pkg::MODE_V86
                     || (r.is32 && !r.conforming && r.tgt_dpl == 2'h0));
                  ncpl = r.conforming ? cpl_r : r.tgt_dpl;
               end else if (!seg_tbl && r.dtype == prot_pkg::DT_TASK_GATE) begin
                  ok = gate_ok && (mode_r != prot_pkg::MODE_V86 || r.is32);
                  ts = 1'b1;
               end
            end
            default: ok = 1'b0;
         endcase
      end
      if (ts) begin
         ncpl = r.tgt_dpl;
         to_v86 = r.img_vm && (mode_r == prot_pkg::MODE_PROT);
         if (to_v86) begin
            ncpl = prot_pkg::V86_CPL;
         end
      end
   end
   assign from_v86 = (mode_r == prot_pkg::MODE_V86) && is_intr;
   assign commit = xfer_valid_in && ok;
   assign xfault = xfer_valid_in && !ok;
   assign sw = ok && !ts && (ncpl != cpl_r);
   assign inward = ncpl < cpl_r;
   // ****************************************
   // Mode, privilege and stack
   // ****************************************
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_r <= prot_pkg::MODE_REAL;
      end else begin
         unique case (mode_r)
            prot_pkg::MODE_REAL: if (pe_r) mode_r <= prot_pkg::MODE_PROT;
            prot_pkg::MODE_PROT: begin
               if (commit && to_v86) begin
                  mode_r <= prot_pkg::MODE_V86;
               end else if (!pe_r) begin
                  mode_r <= prot_pkg::MODE_REAL;
               end
            end
            prot_pkg::MODE_V86: if (commit && from_v86) mode_r <= prot_pkg::MODE_PROT;
            default: mode_r <= prot_pkg::MODE_REAL;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cpl_r <= prot_pkg::CPL_RST;
      end else if (mode_r == prot_pkg::MODE_REAL) begin
         cpl_r <= prot_pkg::CPL_RST;
      end else if (commit) begin
         cpl_r <= ncpl;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         limit_r <= prot_pkg::LIMIT_RST;
      end else if (commit && to_v86) begin
         limit_r <= prot_pkg::V86_LIMIT;
      end
   end
   // Hardware stack switch wins over a software write in the same cycle
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ss_r <= prot_pkg::STK_RST[15:0];
         sp_r <= prot_pkg::STK_RST;
      end else if (commit && sw && inward) begin
         ss_r <= tss_ss_r[ncpl];
         sp_r <= tss_sp_r[ncpl];
      end else if (commit && sw) begin
         ss_r <= r.outer_ss;
         sp_r <= r.outer_sp;
      end else if (reg_wr_in && reg_addr_in == prot_pkg::REG_STK_SEL) begin
         ss_r <= reg_wdata_in[15:0];
      end else if (reg_wr_in && reg_addr_in == prot_pkg::REG_STK_PTR) begin
         sp_r <= reg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xfer_done_out <= 1'b0;
         xfer_rsp_out <= '0;
      end else begin
         xfer_done_out <= xfer_valid_in;
         xfer_rsp_out.fault <= xfault;
         xfer_rsp_out.task_sw <= commit && ts;
         xfer_rsp_out.stk_sw <= commit && sw;
         xfer_rsp_out.push_old <= commit && sw && inward;
         xfer_rsp_out.vm_saved <= commit && from_v86;
         xfer_rsp_out.current_priv_level <= commit ? ncpl : cpl_r;
         xfer_rsp_out.new_ss <= (commit && sw) ? (inward ? tss_ss_r[ncpl] : r.outer_ss) : ss_r;
         xfer_rsp_out.new_sp <= (commit && sw) ? (inward ? tss_sp_r[ncpl] : r.outer_sp) : sp_r;
         xfer_rsp_out.old_ss <= ss_r;
         xfer_rsp_out.old_sp <= sp_r;
      end
   end

   // ****************************************
   // Instruction sensitivity
   // ****************************************
   logic ifault;
   always_comb begin
      ifault = 1'b0;
      if (insn_in == prot_pkg::IN_PRIV) begin
         ifault = (mode_r != prot_pkg::MODE_REAL) && (cpl_r != 2'h0);
      end else if (mode_r == prot_pkg::MODE_V86) begin
         ifault = (insn_in inside {prot_pkg::IN_CLI, prot_pkg::IN_STI, prot_pkg::IN_INTN,
            prot_pkg::IN_IRET, prot_pkg::IN_PUSHF, prot_pkg::IN_POPF}) && (cpl_r > io_priv_level_r);
      end else if (mode_r == prot_pkg::MODE_PROT) begin
         ifault = (insn_in inside {prot_pkg::IN_CLI, prot_pkg::IN_STI, prot_pkg::IN_IO})
            && (cpl_r > io_priv_level_r);
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         insn_done_out <= 1'b0;
         insn_fault_out <= 1'b0;
      end else begin
         insn_done_out <= insn_valid_in;
         insn_fault_out <= insn_valid_in && ifault;
      end
   end
   // ****************************************
   // Address formation
   // ****************************************
   logic [31:0] lin;
   assign lin = {12'h000, seg_in, 4'h0} + off_in;
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         addr_done_out <= 1'b0;
         lin_addr_out <= 32'h00000000;
         overrun_out <= 1'b0;
         page_xlate_out <= 1'b0;
      end else begin
         addr_done_out <= addr_valid_in;
         lin_addr_out <= lin;
         overrun_out <= addr_valid_in && (mode_r == prot_pkg::MODE_V86)
            && (off_in > limit_r || lin > prot_pkg::V86_TOP);
         page_xlate_out <= pg_r && (mode_r != prot_pkg::MODE_REAL);
      end
   end
   // ****************************************
   // Software registers
   // ****************************************
   logic tss_hit;
   assign tss_hit = (reg_addr_in[7:5] == prot_pkg::TSS_BANK) && (reg_addr_in[4:3] != 2'h3);
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pe_r <= 1'b0;
         pg_r <= 1'b0;
         io_priv_level_r <= prot_pkg::IO_PRIV_LEVEL_RST;
         nt_r <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == prot_pkg::REG_CTRL0) begin
         pe_r <= reg_wdata_in[prot_pkg::PE_BIT];
         pg_r <= reg_wdata_in[prot_pkg::PG_BIT];
      end else if (reg_wr_in && reg_addr_in == prot_pkg::REG_FLAGS) begin
         // Emulation flag is not writable here, so a flag pop cannot set it
         io_priv_level_r <= reg_wdata_in[prot_pkg::IO_PRIV_LEVEL_LO +: 2];
         nt_r <= reg_wdata_in[prot_pkg::NT_BIT];
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 3; i++) begin
            tss_ss_r[i] <= prot_pkg::STK_RST[15:0];
            tss_sp_r[i] <= prot_pkg::STK_RST;
         end
      end else if (reg_wr_in && tss_hit && !reg_addr_in[2]) begin
         tss_ss_r[reg_addr_in[4:3]] <= reg_wdata_in[15:0];
      end else if (reg_wr_in && tss_hit) begin
         tss_sp_r[reg_addr_in[4:3]] <= reg_wdata_in;
      end
   end
   // Sticky fault flag: a new fault wins over a write-one clear
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fault_r <= 1'b0;
      end else if (xfault || (insn_valid_in && ifault)) begin
         fault_r <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == prot_pkg::REG_STATUS
         && reg_wdata_in[prot_pkg::ST_FAULT_BIT]) begin
         fault_r <= 1'b0;
      end
   end

   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h00000000;
      if (tss_hit) begin
         rmux = reg_addr_in[2] ? tss_sp_r[reg_addr_in[4:3]] : {16'h0000, tss_ss_r[reg_addr_in[4:3]]};
      end else begin
         unique case (reg_addr_in)
            prot_pkg::REG_CTRL0: begin
               rmux[prot_pkg::PE_BIT] = pe_r;
               rmux[prot_pkg::PG_BIT] = pg_r;
            end
            prot_pkg::REG_FLAGS: begin
               rmux[prot_pkg::IO_PRIV_LEVEL_LO +: 2] = io_priv_level_r;
               rmux[prot_pkg::NT_BIT] = nt_r;
               rmux[prot_pkg::VM_BIT] = (mode_r == prot_pkg::MODE_V86);
            end
            prot_pkg::REG_STATUS: begin
               rmux[1:0] = cpl_r;
               rmux[prot_pkg::ST_MODE_LO +: 3] = mode_r;
               rmux[prot_pkg::ST_FAULT_BIT] = fault_r;
            end
            prot_pkg::REG_STK_SEL: rmux = {16'h0000, ss_r};
            prot_pkg::REG_STK_PTR: rmux = sp_r;
            prot_pkg::REG_LIMIT: rmux = limit_r;
            default: rmux = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 32'h00000000;
      end else begin
         reg_rdata_out <= reg_rd_in ? rmux : 32'h00000000;
      end
   end
   assign current_priv_level_out = cpl_r;
   assign emulation_mode_flag_out = (mode_r == prot_pkg::MODE_V86);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence v86_int_s;
      xfer_valid_in && ok && from_v86 && !ts;
   endsequence
   sequence back_to_prot_s;
      mode_r == prot_pkg::MODE_PROT && !xfer_rsp_out.fault && cpl_r == 2'h0;
   endsequence

   real_stay_a: assert property (mode_r == prot_pkg::MODE_REAL && !pe_r |=>
      mode_r == prot_pkg::MODE_REAL && cpl_r == 2'h0) else $error("real mode left without enable");
   cpl_hold_a: assert property (!commit && mode_r != prot_pkg::MODE_REAL |=>
      $stable(cpl_r)) else $error("privilege changed without transfer");
   bad_type_a: assert property (xfer_valid_in && mode_r == prot_pkg::MODE_PROT
      && r.op == prot_pkg::OP_JMP && r.dtype == prot_pkg::DT_TRAP_GATE |=> xfer_rsp_out.fault)
      else $error("wrong descriptor type accepted");
   gate_epl_a: assert property (xfer_valid_in && mode_r == prot_pkg::MODE_PROT
      && r.dtype == prot_pkg::DT_CALL_GATE && effective_priv_level > r.descriptor_priv_level |=> xfer_done_out
      && xfer_rsp_out.fault) else $error("gate used above its level");
   fault_keep_a: assert property (xfer_done_out && xfer_rsp_out.fault |->
      cpl_r == $past(cpl_r) && sp_r == $past(sp_r)) else $error("faulting transfer changed state");
   stk_load_a: assert property (xfer_valid_in && ok && sw && inward |=>
      ss_r == tss_ss_r[cpl_r] && sp_r == tss_sp_r[cpl_r] && xfer_rsp_out.push_old)
      else $error("inner stack not loaded");
   v86_level_a: assert property (mode_r == prot_pkg::MODE_V86 |->
      cpl_r == prot_pkg::V86_CPL && limit_r == prot_pkg::V86_LIMIT) else $error("emulation level wrong");
   v86_exit_a: assert property (v86_int_s |=> back_to_prot_s ##0 xfer_rsp_out.vm_saved)
      else $error("emulation interrupt entry wrong");
   v86_addr_a: assert property (addr_valid_in && mode_r == prot_pkg::MODE_V86
      && lin > prot_pkg::V86_TOP |=> overrun_out) else $error("overrun missed");
   v86_priv_a: assert property (insn_valid_in && mode_r == prot_pkg::MODE_V86
      && insn_in == prot_pkg::IN_PRIV |=> insn_fault_out) else $error("privileged op allowed");
   io_priv_level_free_a: assert property (insn_valid_in && insn_in inside {prot_pkg::IN_INT3,
      prot_pkg::IN_INTO, prot_pkg::IN_BOUND} |=> !insn_fault_out) else $error("breakpoint form faulted");
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic core_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h00000000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic xfer_valid_in = 1'b0;
   prot_pkg::xfer_req_t xfer_req_in = '0;
   logic xfer_done_out;
   prot_pkg::xfer_rsp_t xfer_rsp_out;
   logic insn_valid_in = 1'b0;
   prot_pkg::insn_t insn_in = prot_pkg::IN_PLAIN;
   logic insn_done_out;
   logic insn_fault_out;
   logic addr_valid_in = 1'b0;
   logic [15:0] seg_in = 16'h0000;
   logic [31:0] off_in = 32'h00000000;
   logic addr_done_out;
   logic [31:0] lin_addr_out;
   logic overrun_out;
   logic page_xlate_out;
   logic [1:0] current_priv_level_out;
   logic emulation_mode_flag_out;
   int mismatches = 0;
   int checks = 0;
   int m_cpl;
   logic [31:0] v, s0, p0, oss, osp;
   prot_pkg::xfer_req_t q;
   priv_xfer_ctrl priv_xfer_ctrl_inst (.core_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .xfer_valid_in, .xfer_req_in, .xfer_done_out, .xfer_rsp_out, .insn_valid_in,
      .insn_in, .insn_done_out, .insn_fault_out, .addr_valid_in, .seg_in, .off_in, .addr_done_out, .lin_addr_out,
      .overrun_out, .page_xlate_out, .current_priv_level_out, .emulation_mode_flag_out);
   initial begin
      forever #50 core_clk_in = ~core_clk_in;
   end
   // ****************************************
   // Bus tasks and model helpers
   // ****************************************
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe, so sample it there
   task rd(input logic [7:0] a);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask
   task xfer(input prot_pkg::xfer_req_t r);
      @(posedge core_clk_in);
      xfer_valid_in <= 1'b1;
      xfer_req_in <= r;
      @(posedge core_clk_in);
      xfer_valid_in <= 1'b0;
      #1 cmp("xfer_done", 1, xfer_done_out);
   endtask
   // Refused transfer: fault reported, level kept
   task fx(input prot_pkg::xfer_req_t r);
      xfer(r);
      cmp("fault", 1, xfer_rsp_out.fault);
      cmp("cpl", m_cpl, current_priv_level_out);
   endtask
   task ins(input prot_pkg::insn_t i, input logic f);
      @(posedge core_clk_in);
      insn_valid_in <= 1'b1;
      insn_in <= i;
      @(posedge core_clk_in);
      insn_valid_in <= 1'b0;
      #1 cmp("insn_done", 1, insn_done_out);
      cmp("insn_fault", f, insn_fault_out);
   endtask
   task ad(input logic [15:0] s, input logic [31:0] o);
      longint e;
      e = s * 16 + o;
      @(posedge core_clk_in);
      addr_valid_in <= 1'b1;
      seg_in <= s;
      off_in <= o;
      @(posedge core_clk_in);
      addr_valid_in <= 1'b0;
      #1 cmp("lin_addr", e[31:0], lin_addr_out);
      cmp("addr_done", 1, addr_done_out);
      cmp("overrun", (e > 64'hfffff || o > 32'hffff), overrun_out);
   endtask
   function automatic prot_pkg::xfer_req_t mk(prot_pkg::op_t o, prot_pkg::dtype_t t, prot_pkg::tbl_t b,
      logic [1:0] d, logic [1:0] g);
      mk = '0;
      mk.op = o;
      mk.dtype = t;
      mk.tbl = b;
      mk.descriptor_priv_level = d;
      mk.tgt_dpl = g;
      mk.is32 = 1'b1;
      mk.outer_ss = oss[15:0];
      mk.outer_sp = osp;
   endfunction
   initial begin
      #3000000 mismatches++;
      stop_test;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      v = $urandom(32'h908548d6);
      s0 = $urandom & 32'hffff;
      p0 = $urandom;
      oss = $urandom & 32'hffff;
      osp = $urandom;
      m_cpl = 0;
      repeat (10) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      rd(prot_pkg::REG_STATUS);
      cmp("status", 32'h00000004, v);
      rd(prot_pkg::REG_LIMIT);
      cmp("limit", prot_pkg::LIMIT_RST, v);
      rd(8'h40);
      cmp("unmapped", 0, v);
      ins(prot_pkg::IN_PRIV, 1'b0);
      wr(8'h20, s0);
      wr(8'h24, p0);
      wr(prot_pkg::REG_CTRL0, 32'h80000001);
      rd(prot_pkg::REG_STATUS);
      cmp("status", 32'h00000008, v);
      cmp("page_xlate", 1, page_xlate_out);
      q = mk(prot_pkg::OP_RET, prot_pkg::DT_CODE, prot_pkg::TB_GLOBAL, 2'h3, 2'h3);
      q.requested_priv_level = 2'h3;
      xfer(q);
      m_cpl = 3;
      cmp("cpl", m_cpl, current_priv_level_out);
      rd(prot_pkg::REG_STK_SEL);
      cmp("stk_sel", oss, v);
      rd(prot_pkg::REG_STK_PTR);
      cmp("stk_ptr", osp, v);
      fx(mk(prot_pkg::OP_CALL, prot_pkg::DT_CALL_GATE, prot_pkg::TB_GLOBAL, 2'h2, 2'h0));
      xfer(mk(prot_pkg::OP_CALL, prot_pkg::DT_CALL_GATE, prot_pkg::TB_LOCAL, 2'h3, 2'h0));
      m_cpl = 0;
      cmp("cpl", m_cpl, xfer_rsp_out.current_priv_level);
      cmp("stk_sw", 1, xfer_rsp_out.stk_sw);
      cmp("new_ss", s0, xfer_rsp_out.new_ss);
      cmp("new_sp", p0, xfer_rsp_out.new_sp);
      cmp("push_old", 1, xfer_rsp_out.push_old);
      cmp("old_sp", osp, xfer_rsp_out.old_sp);
      fx(mk(prot_pkg::OP_CALL, prot_pkg::DT_TRAP_GATE, prot_pkg::TB_GLOBAL, 2'h0, 2'h0));
      fx(mk(prot_pkg::OP_JMP, prot_pkg::DT_CODE, prot_pkg::TB_INTR, 2'h0, 2'h0));
      fx(mk(prot_pkg::OP_JMP, prot_pkg::DT_TSS, prot_pkg::TB_LOCAL, 2'h0, 2'h0));
      q = mk(prot_pkg::OP_CALL, prot_pkg::DT_CALL_GATE, prot_pkg::TB_GLOBAL, 2'h2, 2'h0);
      q.requested_priv_level = 2'h3;
      fx(q);
      rd(prot_pkg::REG_STATUS);
      cmp("status", 32'h00000108, v);
      wr(prot_pkg::REG_STATUS, 32'h00000100);
      rd(prot_pkg::REG_STATUS);
      cmp("status", 32'h00000008, v);
      xfer(mk(prot_pkg::OP_JMP, prot_pkg::DT_CODE, prot_pkg::TB_LOCAL, 2'h0, 2'h0));
      cmp("stk_sw", 0, xfer_rsp_out.stk_sw);
      xfer(mk(prot_pkg::OP_JMP, prot_pkg::DT_TASK_GATE, prot_pkg::TB_GLOBAL, 2'h0, 2'h0));
      cmp("task_sw", 1, xfer_rsp_out.task_sw);
      cmp("stk_sw", 0, xfer_rsp_out.stk_sw);
      cmp("cpl", m_cpl, current_priv_level_out);
      q = mk(prot_pkg::OP_IRET, prot_pkg::DT_CODE, prot_pkg::TB_GLOBAL, 2'h0, 2'h0);
      q.img_vm = 1'b1;
      xfer(q);
      m_cpl = 3;
      cmp("cpl", m_cpl, current_priv_level_out);
      cmp("emu", 1, emulation_mode_flag_out);
      rd(prot_pkg::REG_LIMIT);
      cmp("limit", prot_pkg::V86_LIMIT, v);
      ad(16'($urandom & 16'h7fff), $urandom & 32'hffff);
      ad(16'hffff, 32'h00000010);
      // Level 3 above the reset io level, so every sensitive form except IN_IO must trap
      for (int i = 0; i < 12; i++) begin
         ins(prot_pkg::insn_t'(i), prot_pkg::insn_t'(i) inside {prot_pkg::IN_PRIV, prot_pkg::IN_CLI,
            prot_pkg::IN_STI, prot_pkg::IN_INTN, prot_pkg::IN_IRET, prot_pkg::IN_PUSHF, prot_pkg::IN_POPF});
      end
      cmp("emu", 1, emulation_mode_flag_out);
      q = mk(prot_pkg::OP_EXC, prot_pkg::DT_INT_GATE, prot_pkg::TB_INTR, 2'h0, 2'h0);
      q.is32 = 1'b0;
      fx(q);
      cmp("emu", 1, emulation_mode_flag_out);
      xfer(mk(prot_pkg::OP_EXC, prot_pkg::DT_INT_GATE, prot_pkg::TB_INTR, 2'h0, 2'h0));
      m_cpl = 0;
      cmp("cpl", m_cpl, xfer_rsp_out.current_priv_level);
      cmp("vm_saved", 1, xfer_rsp_out.vm_saved);
      cmp("emu", 0, emulation_mode_flag_out);
      stop_test;
   end
endmodule
`default_nettype wire
